/* rtl/rpcc_pkg.sv */
// constants and types shared by the record/playback cycle control block
package rpcc_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // on-chip oscillator, before the divide by two
  localparam int INT_OSC_HZ = 1_024_000;
  // shortest period, so rounded down
  localparam int INT_TICK_CYC = CLK_HZ / (INT_OSC_HZ / 2);
  // external input held low this long means it is unused
  localparam int EXT_IDLE_NS = 10_000;
  localparam int EXT_IDLE_CYC = (EXT_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least low time of the end-of-message and memory-full pulses
  localparam int EOM_PULSE_NS = 12_500;
  localparam int EOM_PULSE_CYC = (EOM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_PULSE_NS = 12_500;
  localparam int FULL_PULSE_CYC = (FULL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // array geometry
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int TICKS_PER_ROW = 64;

  // ----------------------------------------
  // cycle states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REC = 2'b01,
    ST_PLAY = 2'b10,
    ST_FULL = 2'b11
  } rpcc_state_e;

endpackage

/* rtl/rpcc_clock_select.sv */
// sampling tick source: external clock halved, or on-chip oscillator
`timescale 1ns/1ps
module rpcc_clock_select #(
  parameter int INT_CYC = rpcc_pkg::INT_TICK_CYC,
  parameter int IDLE_CYC = rpcc_pkg::EXT_IDLE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic extSampleClock,
  output logic sampleTick,
  output logic extSelected
);

  localparam int IW = $clog2(INT_CYC + 1);
  localparam int DW = $clog2(IDLE_CYC + 1);

  if (INT_CYC < 2 || IDLE_CYC < 2) begin : g_chk
    $error("rpcc_clock_select: counts too small");
  end

  logic s1, s2, s3, extLevel, extPrev, halfPhase;
  logic [IW-1:0] intCnt;
  logic [DW-1:0] idleCnt;

  // ----------------------------------------
  // synchroniser, change taken when stages two and three agree
  // ----------------------------------------
  wire extRise = extLevel & ~extPrev;
  wire intWrap = (intCnt == IW'(INT_CYC - 1));
  wire idleDone = (idleCnt == DW'(IDLE_CYC));
  // halving means the pin duty cycle never reaches the sampler
  wire extTick = extRise & halfPhase;
  // a grounded pin falls back to the trimmed oscillator
  wire next_sampleTick = extSelected ? extTick : intWrap;

  always_ff @(posedge mclk) begin
    s1 <= extSampleClock;
    s2 <= s1;
    s3 <= s2;
    if (srst) begin
      extLevel <= 1'b0;
      extPrev <= 1'b0;
      halfPhase <= 1'b0;
      intCnt <= '0;
      idleCnt <= '0;
      extSelected <= 1'b0;
      sampleTick <= 1'b0;
    end else begin
      if (s2 == s3) begin
        extLevel <= s3;
      end
      extPrev <= extLevel;
      if (extRise) begin
        halfPhase <= ~halfPhase;
      end
      intCnt <= intWrap ? '0 : intCnt + IW'(1);
      if (extLevel) begin
        idleCnt <= '0;
      end else if (!idleDone) begin
        idleCnt <= idleCnt + DW'(1);
      end
      if (extRise) begin
        extSelected <= 1'b1;
      end else if (idleDone) begin
        extSelected <= 1'b0;
      end
      sampleTick <= next_sampleTick;
    end
  end

endmodule

/* rtl/rpcc_top.sv */
// record/playback cycle control: pin capture, pointer, end markers, flags
`timescale 1ns/1ps
module rpcc_top #(
  parameter int ADDR_W = rpcc_pkg::ADDR_W,
  parameter int TICKS_PER_ROW = rpcc_pkg::TICKS_PER_ROW,
  parameter int EOM_CYC = rpcc_pkg::EOM_PULSE_CYC,
  parameter int FULL_CYC = rpcc_pkg::FULL_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic extSampleClock,
  input wire logic deviceSelectN,
  input wire logic playRecord,
  input wire logic standbyRequest,
  input wire logic [ADDR_W-1:0] addrPins,
  input wire logic modePassEom,
  output logic messageEndMarkerN,
  output logic memoryFullN,
  output logic recordActive,
  output logic playActive,
  output logic markerWrite,
  output logic [ADDR_W-1:0] addrPointer
);

  localparam int ROWS = 1 << ADDR_W;
  localparam int TW = $clog2(TICKS_PER_ROW + 1);
  localparam int EW = $clog2(EOM_CYC + 1);
  localparam int FW = $clog2(FULL_CYC + 1);
  localparam int SW = ADDR_W + 4;

  if (ADDR_W < 3 || TICKS_PER_ROW < 1 || EOM_CYC < 1 || FULL_CYC < 1) begin : g_chk
    $error("rpcc_top: parameter out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [SW-1:0] pinRaw = {deviceSelectN, playRecord, standbyRequest, modePassEom, addrPins};
  logic [SW-1:0] syn1, syn2, syn3, pinF;

  for (genvar i = 0; i < SW; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      syn1[i] <= pinRaw[i];
      syn2[i] <= syn1[i];
      syn3[i] <= syn2[i];
      if (srst) begin
        pinF[i] <= (i == SW - 1) ? 1'b1 : 1'b0;
      end else if (syn2[i] == syn3[i]) begin
        pinF[i] <= syn3[i];
      end
    end
  end

  wire selN = pinF[SW-1];
  wire dirPlay = pinF[SW-2];
  wire standby = pinF[SW-3];
  // the mode pin is a pin like the others, so it is filtered too
  wire modePass = pinF[SW-4];
  wire [ADDR_W-1:0] addrF = pinF[ADDR_W-1:0];

  // ----------------------------------------
  // sampling tick
  // ----------------------------------------
  logic sampleTick;

  rpcc_clock_select u_clk (
    .mclk(mclk),
    .srst(srst),
    .extSampleClock(extSampleClock),
    .sampleTick(sampleTick),
    .extSelected()
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  rpcc_pkg::rpcc_state_e state, next_state;
  logic selPrev;
  logic directMode;
  logic [TW-1:0] tickCnt;
  logic [EW-1:0] eomCnt;
  logic [FW-1:0] fullCnt;
  // one end marker per row; cleared as the row is recorded over
  logic markerMem [ROWS];

  // shared by overflow detection and pointer stepping
  function automatic logic is_running(input rpcc_pkg::rpcc_state_e s);
    return (s == rpcc_pkg::ST_REC) || (s == rpcc_pkg::ST_PLAY);
  endfunction

  wire selFall = selPrev & ~selN;
  // falling select only starts a cycle from idle
  wire startCycle = selFall & ~standby & (state == rpcc_pkg::ST_IDLE);
  wire rowStep = sampleTick & (tickCnt == TW'(TICKS_PER_ROW - 1));
  wire atLastRow = (addrPointer == {ADDR_W{1'b1}});
  wire markerHere = markerMem[addrPointer];
  wire inRec = (state == rpcc_pkg::ST_REC);
  wire inPlay = (state == rpcc_pkg::ST_PLAY);
  wire running = is_running(state);
  // record is level-held: either pin going high ends it
  wire recStop = inRec & (standby | selN);
  wire passMarker = (directMode & ~selN) | modePass;
  wire playEnd = inPlay & rowStep & markerHere & ~passMarker;
  wire overflow = running & rowStep & atLastRow & ~recStop & ~playEnd;
  wire modeAddr = addrF[ADDR_W-1] & addrF[ADDR_W-2];

  always_comb begin
    next_state = state;
    unique case (state)
      rpcc_pkg::ST_IDLE: begin
        if (startCycle) begin
          next_state = dirPlay ? rpcc_pkg::ST_PLAY : rpcc_pkg::ST_REC;
        end
      end
      rpcc_pkg::ST_REC: begin
        if (recStop) begin
          next_state = rpcc_pkg::ST_IDLE;
        end else if (overflow) begin
          next_state = rpcc_pkg::ST_FULL;
        end
      end
      rpcc_pkg::ST_PLAY: begin
        if (standby || playEnd) begin
          next_state = rpcc_pkg::ST_IDLE;
        end else if (overflow) begin
          next_state = rpcc_pkg::ST_FULL;
        end
      end
      rpcc_pkg::ST_FULL: begin
        // only the standby request leaves the full condition
        if (standby) begin
          next_state = rpcc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= rpcc_pkg::ST_IDLE;
      selPrev <= 1'b1;
    end else begin
      state <= next_state;
      selPrev <= selN;
    end
  end

  // ----------------------------------------
  // start capture and row pointer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      directMode <= 1'b1;
      addrPointer <= '0;
      tickCnt <= '0;
    end else begin
      if (startCycle) begin
        // start address and addressing mode latched here only, later changes are ignored
        addrPointer <= addrF;
        directMode <= ~modeAddr;
        tickCnt <= '0;
      end else if (standby) begin
        addrPointer <= '0;
        tickCnt <= '0;
      end else if (running && sampleTick) begin
        tickCnt <= rowStep ? '0 : tickCnt + TW'(1);
        if (rowStep && !atLastRow && !recStop && !playEnd) begin
          addrPointer <= addrPointer + ADDR_W'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // end markers
  // ----------------------------------------
  // no reset: the array stands for non-volatile storage
  always_ff @(posedge mclk) begin
    if (recStop) begin
      markerMem[addrPointer] <= 1'b1;
    end else if (inRec && rowStep) begin
      markerMem[addrPointer] <= 1'b0;
    end
  end

  // ----------------------------------------
  // output pulses and status
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      eomCnt <= '0;
      messageEndMarkerN <= 1'b1;
    end else begin
      if (playEnd) begin
        eomCnt <= EW'(EOM_CYC);
      end else if (eomCnt != '0) begin
        eomCnt <= eomCnt - EW'(1);
      end
      messageEndMarkerN <= ~(playEnd | (eomCnt > EW'(1)));
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      fullCnt <= '0;
      memoryFullN <= 1'b1;
    end else begin
      if (overflow) begin
        fullCnt <= FW'(FULL_CYC);
      end else if (fullCnt != '0) begin
        fullCnt <= fullCnt - FW'(1);
      end
      // after the pulse the flag mirrors select, for cascading
      if (overflow || fullCnt > FW'(1)) begin
        memoryFullN <= 1'b0;
      end else if (next_state == rpcc_pkg::ST_FULL) begin
        memoryFullN <= selN;
      end else begin
        memoryFullN <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      recordActive <= 1'b0;
      playActive <= 1'b0;
      markerWrite <= 1'b0;
    end else begin
      recordActive <= (next_state == rpcc_pkg::ST_REC);
      playActive <= (next_state == rpcc_pkg::ST_PLAY);
      markerWrite <= recStop;
    end
  end

endmodule

/* verif/rpcc_top_chk.sv */
// assertions on the cycle control pins
`timescale 1ns/1ps
module rpcc_top_chk #(
  parameter int ADDR_W = 10,
  parameter int EOM_CYC = 250
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic extSampleClock,
  input wire logic deviceSelectN,
  input wire logic playRecord,
  input wire logic standbyRequest,
  input wire logic [ADDR_W-1:0] addrPins,
  input wire logic modePassEom,
  input wire logic messageEndMarkerN,
  input wire logic memoryFullN,
  input wire logic recordActive,
  input wire logic playActive,
  input wire logic markerWrite,
  input wire logic [ADDR_W-1:0] addrPointer
);
  // ----------------
  // helpers
  // ----------------
  logic [15:0] eomLow;
  always_ff @(posedge mclk) begin
    if (srst || messageEndMarkerN) eomLow <= 16'h0000;
    else eomLow <= eomLow + 16'h0001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_rec_stop;
    $past(recordActive) && !recordActive;
  endsequence
  // ----------------
  // properties
  // ----------------
  a_rec_start: assert property ($rose(recordActive) |-> addrPointer == addrPins)
    else $error("record did not start at the pin address");
  a_play_start: assert property ($rose(playActive) |-> addrPointer == addrPins)
    else $error("playback did not start at the pin address");
  a_one_cycle: assert property (!(recordActive && playActive))
    else $error("record and playback active together");
  a_marker_stop: assert property (markerWrite |-> s_rec_stop)
    else $error("marker write outside a record stop");
  a_marker_single: assert property (markerWrite |=> !markerWrite)
    else $error("marker write longer than one cycle");
  a_eom_width: assert property ($rose(messageEndMarkerN) |-> eomLow == 16'(EOM_CYC))
    else $error("end-of-message pulse width wrong");
  a_eom_ends: assert property ($fell(messageEndMarkerN) |-> ##[0:2] !playActive)
    else $error("playback kept running after end marker");
  a_full_stop: assert property ($fell(memoryFullN) |-> ##[0:2] !(recordActive || playActive))
    else $error("cycle kept running after memory full");
  a_standby_home: assert property ($rose(standbyRequest) |-> ##[1:8] addrPointer == '0)
    else $error("standby did not return pointer to start");
endmodule
bind rpcc_top rpcc_top_chk #(.ADDR_W(ADDR_W), .EOM_CYC(EOM_CYC)) u_chk (.mclk(mclk),
  .srst(srst), .extSampleClock(extSampleClock), .deviceSelectN(deviceSelectN),
  .playRecord(playRecord), .standbyRequest(standbyRequest), .addrPins(addrPins),
  .modePassEom(modePassEom), .messageEndMarkerN(messageEndMarkerN), .memoryFullN(memoryFullN),
  .recordActive(recordActive), .playActive(playActive), .markerWrite(markerWrite),
  .addrPointer(addrPointer));

/* verif/rpcc_mcu_model.sv */
// controller model driving the control pins
`timescale 1ns/1ps
module rpcc_mcu_model (
  input wire logic mclk,
  output logic extSampleClock,
  output logic deviceSelectN,
  output logic playRecord,
  output logic standbyRequest,
  output logic [3:0] addrPins,
  output logic modePassEom
);
  // ----------------
  // pins
  // ----------------
  logic extRun = 1'b0;
  logic [1:0] div = 2'h0;
  initial begin
    {extSampleClock, playRecord, standbyRequest, modePassEom} = 4'h0;
    deviceSelectN = 1'b1;
    addrPins = 4'h0;
  end
  // fixed rate only: a wandering rate would alias in the fixed filters
  always @(negedge mclk) begin
    div <= div + 2'h1;
    if (!extRun) extSampleClock <= 1'b0;
    else if (div == 2'h3) extSampleClock <= ~extSampleClock;
  end
  task automatic go(input logic dir, input logic [3:0] a);
    @(negedge mclk);
    deviceSelectN = 1'b1;
    playRecord = dir;
    addrPins = a;
    // select must pass the pin filter high before the next fall counts
    repeat (6) @(negedge mclk);
    deviceSelectN = 1'b0;
  endtask
  task automatic sel(input logic v);
    @(negedge mclk);
    deviceSelectN = v;
  endtask
  task automatic standby();
    @(negedge mclk);
    standbyRequest = 1'b1;
    repeat (10) @(negedge mclk);
    standbyRequest = 1'b0;
  endtask
endmodule

/* verif/tb_rpcc_top.sv */
// self-checking bench for the cycle control
`timescale 1ns/1ps
module tb_rpcc_top;
  // ----------------
  // setup
  // ----------------
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic extSampleClock, deviceSelectN, playRecord, standbyRequest, modePassEom;
  logic [3:0] addrPins, addrPointer, markRow;
  logic messageEndMarkerN, memoryFullN, recordActive, playActive, markerWrite;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  rpcc_top #(.ADDR_W(4), .TICKS_PER_ROW(2), .EOM_CYC(8), .FULL_CYC(8)) u_dut (.mclk(mclk),
    .srst(srst), .extSampleClock(extSampleClock), .deviceSelectN(deviceSelectN),
    .playRecord(playRecord), .standbyRequest(standbyRequest), .addrPins(addrPins),
    .modePassEom(modePassEom), .messageEndMarkerN(messageEndMarkerN),
    .memoryFullN(memoryFullN), .recordActive(recordActive), .playActive(playActive),
    .markerWrite(markerWrite), .addrPointer(addrPointer));
  rpcc_mcu_model u_mcu (.mclk(mclk), .extSampleClock(extSampleClock),
    .deviceSelectN(deviceSelectN), .playRecord(playRecord), .standbyRequest(standbyRequest),
    .addrPins(addrPins), .modePassEom(modePassEom));
  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return recordActive;
      1: return playActive;
      2: return markerWrite;
      3: return messageEndMarkerN;
      default: return memoryFullN;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && sig(k) !== v; n++) begin
      @(posedge mclk);
      #1;
    end
    check("wait", {3'h0, sig(k)}, {3'h0, v});
  endtask
  task automatic wait_row(input logic [3:0] row, input int lim);
    int n;
    for (n = 0; n < lim && addrPointer !== row; n++) begin
      @(posedge mclk);
      #1;
    end
    check("row", addrPointer, row);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_record();
    u_mcu.go(1'b0, 4'h3);
    wait_for(0, 1'b1, 40);
    check("rec start", addrPointer, 4'h3);
    repeat (100) @(negedge mclk);
    u_mcu.playRecord = 1'b1;
    repeat (100) @(negedge mclk);
    check("dir held", {2'h0, playActive, recordActive}, 4'h1);
    u_mcu.sel(1'b1);
    wait_for(2, 1'b1, 40);
    markRow = addrPointer;
    check("rows moved", {3'h0, markRow > 4'h3}, 4'h1);
    wait_for(0, 1'b0, 4);
    $display("record test done");
  endtask
  task automatic t_play();
    u_mcu.go(1'b1, 4'h3);
    wait_for(1, 1'b1, 40);
    check("play start", addrPointer, 4'h3);
    u_mcu.sel(1'b1);
    wait_for(3, 1'b0, 2000);
    check("eom row", addrPointer, markRow);
    repeat (7) @(posedge mclk);
    #1 check("eom low", {3'h0, messageEndMarkerN}, 4'h0);
    @(posedge mclk);
    #1 check("eom end", {3'h0, messageEndMarkerN, playActive}, 4'h2);
    $display("playback test done");
  endtask
  task automatic t_pass();
    u_mcu.go(1'b1, 4'h3);
    wait_row(markRow + 4'h1, 800);
    check("passed", {3'h0, playActive}, 4'h1);
    u_mcu.standby();
    check("standby end", {3'h0, playActive}, 4'h0);
    u_mcu.modePassEom = 1'b1;
    u_mcu.go(1'b1, 4'h3);
    wait_for(1, 1'b1, 40);
    u_mcu.sel(1'b1);
    wait_row(markRow + 4'h1, 800);
    check("mode passed", {3'h0, playActive}, 4'h1);
    u_mcu.standby();
    u_mcu.modePassEom = 1'b0;
    check("mode end", {3'h0, playActive}, 4'h0);
    $display("pass test done");
  endtask
  task automatic t_mode();
    u_mcu.go(1'b0, 4'hD);
    wait_row(4'hE, 200);
    u_mcu.sel(1'b1);
    wait_for(2, 1'b1, 40);
    check("mode mark", addrPointer, 4'hE);
    u_mcu.go(1'b1, 4'hC);
    wait_for(3, 1'b0, 400);
    check("mode stop", addrPointer, 4'hE);
    repeat (10) @(negedge mclk);
    $display("mode address test done");
  endtask
  task automatic t_refuse();
    @(negedge mclk) u_mcu.standbyRequest = 1'b1;
    u_mcu.go(1'b0, 4'h5);
    repeat (20) @(negedge mclk);
    check("refused", {2'h0, playActive, recordActive}, 4'h0);
    u_mcu.sel(1'b1);
    u_mcu.standbyRequest = 1'b0;
    $display("refuse test done");
  endtask
  task automatic t_full();
    u_mcu.go(1'b0, 4'hB);
    wait_for(4, 1'b0, 1500);
    repeat (20) @(negedge mclk);
    check("full follow", {2'h0, memoryFullN, recordActive}, 4'h0);
    u_mcu.sel(1'b1);
    repeat (10) @(negedge mclk);
    check("full high", {3'h0, memoryFullN}, 4'h1);
    u_mcu.standby();
    check("home", addrPointer, 4'h0);
    $display("full test done");
  endtask
  task automatic t_ext();
    @(negedge mclk) u_mcu.extRun = 1'b1;
    repeat (20) @(negedge mclk);
    u_mcu.go(1'b0, 4'h0);
    wait_for(0, 1'b1, 40);
    repeat (160) @(negedge mclk);
    // internal ticks would manage two rows here
    check("ext rows", {3'h0, addrPointer >= 4'h4}, 4'h1);
    u_mcu.sel(1'b1);
    u_mcu.extRun = 1'b0;
    $display("external clock test done");
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    t_record();
    t_play();
    t_pass();
    t_refuse();
    t_full();
    t_mode();
    t_ext();
    give_verdict();
  end
endmodule
